// File: shared/pdt_pkg.sv
// Purpose: Constants for the two pairable 16/32-bit timer pairs
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit byte address
// Notes:   Timer index 0..3: pair A even, pair A odd, pair B even, pair B odd
`default_nettype none
package pdt_pkg;
  // Address map: one 16-byte window per timer, then shared registers
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_COUNT    = 8'h04;
  localparam logic [7:0] OFF_PERIOD   = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h40;
  localparam logic [7:0] OFF_MASK     = 8'h44;
  localparam logic [1:0] SEL_CTRL     = 2'h0;
  localparam logic [1:0] SEL_COUNT    = 2'h1;
  localparam logic [1:0] SEL_PERIOD   = 2'h2;

  // Control register field positions
  localparam int BIT_RUN    = 15;
  localparam int BIT_IDLE   = 13;
  localparam int BIT_GATE   = 6;
  localparam int BIT_PSC_HI = 5;
  localparam int BIT_PSC_LO = 4;
  localparam int BIT_PAIR   = 3;
  localparam int BIT_CS     = 1;

  // Implemented bits; everything else reads as zero
  localparam logic [15:0] CTRL_MASK_EVEN = 16'hA07A;
  localparam logic [15:0] CTRL_MASK_ODD  = 16'hA072;

  // Prescale terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PSC_LIM_1   = 8'h00;
  localparam logic [7:0] PSC_LIM_8   = 8'h07;
  localparam logic [7:0] PSC_LIM_64  = 8'h3F;
  localparam logic [7:0] PSC_LIM_256 = 8'hFF;

  // Values after reset
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [3:0]  MASK_RST   = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: logic/pdt_timer_pairs.sv
// Purpose: Two timer pairs, each two 16-bit timers or one 32-bit timer
// Assumes: clk_in is the oscillator; internal tick is clk_in/2
// Notes:   Pins are synchronous to clk_in; registers over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module pdt_timer_pairs (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Timer pins and device state
  input  wire logic [3:0]  ext_clock_pin_in,
  input  wire logic        idle_mode_in,
  // Events
  output logic             irq_out,
  output logic             adc_trigger_out
);

  typedef struct packed {
    logic [3:0][15:0] ctrl;
    logic [3:0][15:0] cnt;
    logic [3:0][15:0] per;
    logic [3:0][7:0]  psc;
    logic [3:0]       pin_prev;
    logic             half;
    logic [3:0]       status;
    logic [3:0]       mask;
    logic             adc;
    logic             aw_full;
    logic [7:0]       aw_addr;
    logic             w_full;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } pdt_state_s;

  pdt_state_s st_reg;
  pdt_state_s st_next;
  logic [3:0] tick_v;
  logic [3:0] ev_v;
  logic [3:0] clr_v;
  logic       wr_go;

  // Prescale terminal count for a select code
  function automatic logic [7:0] psc_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    psc_limit = pdt_pkg::PSC_LIM_1;
      2'h1:    psc_limit = pdt_pkg::PSC_LIM_8;
      2'h2:    psc_limit = pdt_pkg::PSC_LIM_64;
      default: psc_limit = pdt_pkg::PSC_LIM_256;
    endcase
  endfunction

  // Source edge through prescaler; returns {tick, next prescale count}
  function automatic logic [8:0] tick_step(
    input logic [15:0] ctl,
    input logic        pin,
    input logic        prev,
    input logic        half,
    input logic [7:0]  psc,
    input logic        live
  );
    logic       raw;
    logic [7:0] lim;
    // Pin edges are seen on clk_in, so only synchronous counting exists
    raw = ctl[pdt_pkg::BIT_CS] ? (pin & ~prev)
        : (half & (~ctl[pdt_pkg::BIT_GATE] | pin));
    lim = psc_limit(ctl[pdt_pkg::BIT_PSC_HI:pdt_pkg::BIT_PSC_LO]);
    tick_step = {1'b0, psc};
    if (live && raw) begin
      tick_step = (psc == lim) ? {1'b1, 8'h00}
                               : {1'b0, psc + 8'h01};
    end
  endfunction

  // 16-bit step; returns {match, next count}
  function automatic logic [16:0] step16(
    input logic [15:0] cnt,
    input logic [15:0] per
  );
    step16 = (cnt == per) ? {1'b1, 16'h0000}
                          : {1'b0, cnt + 16'h0001};
  endfunction

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    merge16[7:0]  = strb[0] ? data[7:0] : old[7:0];
    merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
  endfunction

  // Whole next state: timers, register writes, bus handshakes
  always_comb begin
    logic [8:0]  ts;
    logic [16:0] s16;
    logic [31:0] c32;
    logic [31:0] p32;
    logic        live;
    logic [1:0]  tix;
    logic [1:0]  sel;
    logic [15:0] cm;
    int          e;
    ts   = 9'h000;
    s16  = 17'h00000;
    c32  = 32'h00000000;
    p32  = 32'h00000000;
    live = 1'b0;
    tix  = 2'h0;
    sel  = 2'h0;
    cm   = 16'h0000;
    e    = 0;
    st_next  = st_reg;
    tick_v   = 4'h0;
    ev_v     = 4'h0;
    clr_v    = 4'h0;
    st_next.half     = ~st_reg.half;
    st_next.pin_prev = ext_clock_pin_in;
    wr_go = st_reg.aw_full & st_reg.w_full & ~st_reg.bvalid;

    // Prescalers; the odd one sleeps while its pair is joined
    for (int t = 0; t < 4; t++) begin
      live = st_reg.ctrl[t][pdt_pkg::BIT_RUN] &&
             !(idle_mode_in && st_reg.ctrl[t][pdt_pkg::BIT_IDLE]);
      if (t[0] && st_reg.ctrl[t - 1][pdt_pkg::BIT_PAIR]) begin
        live = 1'b0;
      end
      ts = tick_step(st_reg.ctrl[t], ext_clock_pin_in[t],
                     st_reg.pin_prev[t], st_reg.half, st_reg.psc[t], live);
      tick_v[t]      = ts[8];
      st_next.psc[t] = ts[7:0];
    end

    // Counters per pair
    for (int p = 0; p < 2; p++) begin
      e = 2 * p;
      if (st_reg.ctrl[e][pdt_pkg::BIT_PAIR]) begin
        c32 = {st_reg.cnt[e + 1], st_reg.cnt[e]};
        p32 = {st_reg.per[e + 1], st_reg.per[e]};
        if (tick_v[e]) begin
          if (c32 == p32) begin
            c32 = 32'h00000000;
            ev_v[e + 1] = 1'b1;
          end else begin
            c32 = c32 + 32'h00000001;
          end
        end
        st_next.cnt[e + 1] = c32[31:16];
        st_next.cnt[e]     = c32[15:0];
      end else begin
        for (int k = 0; k < 2; k++) begin
          if (tick_v[e + k]) begin
            s16 = step16(st_reg.cnt[e + k], st_reg.per[e + k]);
            st_next.cnt[e + k] = s16[15:0];
            ev_v[e + k]        = s16[16];
          end
        end
      end
    end

    // Only pair A odd position drives the converter trigger
    st_next.adc = ev_v[1];

    // Write address and data are taken independently
    if (s_axi_awvalid_in && !st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st_reg.w_full) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata_in;
      st_next.w_strb = s_axi_wstrb_in;
    end
    if (st_reg.bvalid && s_axi_bready_in) begin
      st_next.bvalid = 1'b0;
    end

    // Commit a write once both halves are held; software beats counting
    if (wr_go) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = pdt_pkg::RESP_OKAY;
      tix = st_reg.aw_addr[5:4];
      sel = st_reg.aw_addr[3:2];
      cm  = tix[0] ? pdt_pkg::CTRL_MASK_ODD : pdt_pkg::CTRL_MASK_EVEN;
      if (st_reg.aw_addr < pdt_pkg::OFF_STATUS && sel == pdt_pkg::SEL_CTRL) begin
        st_next.ctrl[tix] = merge16(st_reg.ctrl[tix], st_reg.w_data,
                                    st_reg.w_strb) & cm;
        st_next.psc[tix]  = 8'h00;
      end else if (st_reg.aw_addr < pdt_pkg::OFF_STATUS &&
                   sel == pdt_pkg::SEL_COUNT) begin
        st_next.cnt[tix] = merge16(st_reg.cnt[tix], st_reg.w_data,
                                   st_reg.w_strb);
      end else if (st_reg.aw_addr < pdt_pkg::OFF_STATUS &&
                   sel == pdt_pkg::SEL_PERIOD) begin
        st_next.per[tix] = merge16(st_reg.per[tix], st_reg.w_data,
                                   st_reg.w_strb);
      end else if (st_reg.aw_addr[7:2] == pdt_pkg::OFF_STATUS[7:2]) begin
        clr_v = st_reg.w_strb[0] ? st_reg.w_data[3:0] : 4'h0;
      end else if (st_reg.aw_addr[7:2] == pdt_pkg::OFF_MASK[7:2]) begin
        if (st_reg.w_strb[0]) begin
          st_next.mask = st_reg.w_data[3:0];
        end
      end else begin
        st_next.bresp = pdt_pkg::RESP_SLVERR;
      end
    end

    // Sticky flags: a new event outweighs a clear in the same cycle
    st_next.status = (st_reg.status & ~clr_v) | ev_v;

    // Read channel: one outstanding read, answered the cycle after
    if (st_reg.rvalid && s_axi_rready_in) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && !st_reg.rvalid) begin
      tix = s_axi_araddr_in[5:4];
      sel = s_axi_araddr_in[3:2];
      st_next.rvalid = 1'b1;
      st_next.rresp  = pdt_pkg::RESP_OKAY;
      st_next.rdata  = 32'h00000000;
      if (s_axi_araddr_in < pdt_pkg::OFF_STATUS && sel == pdt_pkg::SEL_CTRL) begin
        st_next.rdata[15:0] = st_reg.ctrl[tix];
      end else if (s_axi_araddr_in < pdt_pkg::OFF_STATUS &&
                   sel == pdt_pkg::SEL_COUNT) begin
        st_next.rdata[15:0] = st_reg.cnt[tix];
      end else if (s_axi_araddr_in < pdt_pkg::OFF_STATUS &&
                   sel == pdt_pkg::SEL_PERIOD) begin
        st_next.rdata[15:0] = st_reg.per[tix];
      end else if (s_axi_araddr_in[7:2] == pdt_pkg::OFF_STATUS[7:2]) begin
        st_next.rdata[3:0] = st_reg.status;
      end else if (s_axi_araddr_in[7:2] == pdt_pkg::OFF_MASK[7:2]) begin
        st_next.rdata[3:0] = st_reg.mask;
      end else begin
        st_next.rresp = pdt_pkg::RESP_SLVERR;
      end
    end

    // Synchronous reset state
    if (!reset_n_in) begin
      st_next = '0;
      st_next.ctrl = {4{pdt_pkg::CTRL_RST}};
      st_next.cnt  = {4{pdt_pkg::COUNT_RST}};
      st_next.per  = {4{pdt_pkg::PERIOD_RST}};
      st_next.mask = pdt_pkg::MASK_RST;
    end
  end

  // Single state register
  always_ff @(posedge clk_in) begin
    st_reg <= st_next;
  end

  // Ready signals are combinational off held state
  assign s_axi_awready_out = ~st_reg.aw_full;
  assign s_axi_wready_out  = ~st_reg.w_full;
  assign s_axi_arready_out = ~st_reg.rvalid;
  assign s_axi_bvalid_out  = st_reg.bvalid;
  assign s_axi_bresp_out   = st_reg.bresp;
  assign s_axi_rvalid_out  = st_reg.rvalid;
  assign s_axi_rdata_out   = st_reg.rdata;
  assign s_axi_rresp_out   = st_reg.rresp;
  assign adc_trigger_out   = st_reg.adc;
  assign irq_out           = |(st_reg.status & st_reg.mask);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_pair_match;
    st_reg.ctrl[0][pdt_pkg::BIT_PAIR] && tick_v[0] && !wr_go &&
    ({st_reg.cnt[1], st_reg.cnt[0]} == {st_reg.per[1], st_reg.per[0]});
  endsequence
  sequence s_pair_zeroed;
    st_reg.cnt[0] == 16'h0000 && st_reg.cnt[1] == 16'h0000 &&
    st_reg.status[1];
  endsequence

  a_pair_match_wrap:
    assert property (s_pair_match |=> s_pair_zeroed and adc_trigger_out)
    else $error("paired match did not wrap, flag and trigger");

  a_pair_lo_carry:
    assert property (st_reg.ctrl[0][pdt_pkg::BIT_PAIR] && tick_v[0] &&
      !wr_go && st_reg.cnt[0] == 16'hFFFF &&
      {st_reg.cnt[1], st_reg.cnt[0]} != {st_reg.per[1], st_reg.per[0]}
      |=> st_reg.cnt[0] == 16'h0000 &&
          st_reg.cnt[1] == $past(st_reg.cnt[1]) + 16'h0001)
    else $error("lower word wrap did not carry");

  a_pair_odd_silent:
    assert property (st_reg.ctrl[0][pdt_pkg::BIT_PAIR] |-> !tick_v[1])
    else $error("odd timer ticked while paired");

  a_pair_even_flag:
    assert property (st_reg.ctrl[0][pdt_pkg::BIT_PAIR] && !st_reg.status[0]
      |=> !st_reg.status[0])
    else $error("even flag set in paired mode");

  a_pair_stop_hold:
    assert property (st_reg.ctrl[0][pdt_pkg::BIT_PAIR] &&
      !st_reg.ctrl[0][pdt_pkg::BIT_RUN] && !wr_go
      |=> $stable(st_reg.cnt[0]) && $stable(st_reg.cnt[1]))
    else $error("stopped pair kept counting");

  a_single_wrap:
    assert property (!st_reg.ctrl[0][pdt_pkg::BIT_PAIR] && tick_v[0] &&
      !wr_go && st_reg.cnt[0] == st_reg.per[0]
      |=> st_reg.cnt[0] == 16'h0000 && st_reg.status[0])
    else $error("16-bit match did not wrap and flag");

  a_idle_halt:
    assert property (idle_mode_in && st_reg.ctrl[2][pdt_pkg::BIT_IDLE] &&
      !st_reg.ctrl[2][pdt_pkg::BIT_PAIR] |-> !tick_v[2])
    else $error("timer ticked in idle with stop set");

  a_gate_block:
    assert property (!st_reg.ctrl[0][pdt_pkg::BIT_CS] &&
      st_reg.ctrl[0][pdt_pkg::BIT_GATE] && !ext_clock_pin_in[0]
      |-> !tick_v[0])
    else $error("gated timer ticked with gate low");

  a_ext_edge_only:
    assert property (tick_v[0] && st_reg.ctrl[0][pdt_pkg::BIT_CS]
      |-> ext_clock_pin_in[0] && !st_reg.pin_prev[0])
    else $error("external tick without rising edge");

  a_psc_terminal:
    assert property (tick_v[0] |-> st_reg.psc[0] == psc_limit(
      st_reg.ctrl[0][pdt_pkg::BIT_PSC_HI:pdt_pkg::BIT_PSC_LO]))
    else $error("tick before prescale terminal count");

  a_ctrl_psc_clear:
    assert property (wr_go && st_reg.aw_addr == pdt_pkg::OFF_CTRL
      |=> st_reg.psc[0] == 8'h00)
    else $error("control write kept prescale count");

  a_ctrl_unimpl_zero:
    assert property ((st_reg.ctrl[0] & ~pdt_pkg::CTRL_MASK_EVEN) == 16'h0000
      && (st_reg.ctrl[1] & ~pdt_pkg::CTRL_MASK_ODD) == 16'h0000)
    else $error("unimplemented control bit set");

  a_adc_source:
    assert property (ev_v[3] && !ev_v[1] |=> !adc_trigger_out)
    else $error("pair B raised the converter trigger");

  a_bresp_hold:
    assert property (st_reg.bvalid && !s_axi_bready_in
      |=> st_reg.bvalid && $stable(st_reg.bresp))
    else $error("write response dropped before ready");

endmodule
`default_nettype wire

// File: verif/pdt_pin_model.sv
// Purpose: Model of the timer clock and gate pins outside the block
// Assumes: Pins idle low and change just after a rising clk_in edge
// Notes:   Each edge is three clocks high and three low, so none is missed
`timescale 1ns/1ps
`default_nettype none
module pdt_pin_model (
  // Clock
  input  wire logic       clk_in,
  // Timer pins
  output logic      [3:0] pins_out
);
  // Pins rest low between bursts so no stray edge is counted
  initial pins_out = 4'h0;

  // Burst of rising edges on one pin, aligned to clk_in
  task automatic pulse(input int idx, input int cnt);
    repeat (cnt) begin
      @(posedge clk_in);
      pins_out[idx] <= 1'b1;
      repeat (3) @(posedge clk_in);
      pins_out[idx] <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Purpose: Self-checking bench for the two pairable timer pairs
// Assumes: Register map and bus latencies as handed over with the design
// Notes:   Read data and write responses are judged by a watcher process
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] C_RUN  = 16'h8000;
  localparam logic [15:0] C_IDLE = 16'h2000;
  localparam logic [15:0] C_GATE = 16'h0040;
  localparam logic [15:0] C_PAIR = 16'h0008;
  localparam logic [15:0] C_EXT  = 16'h0002;
  localparam logic [7:0]  CT     = pdt_pkg::OFF_CTRL;
  localparam logic [7:0]  CN     = pdt_pkg::OFF_COUNT;
  localparam logic [7:0]  PE     = pdt_pkg::OFF_PERIOD;
  localparam logic [7:0]  ST     = pdt_pkg::OFF_STATUS;
  localparam logic [7:0]  MK     = pdt_pkg::OFF_MASK;
  localparam logic [1:0]  OK     = pdt_pkg::RESP_OKAY;
  logic        clk_in     = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [7:0]  awaddr     = 8'h00;
  logic [7:0]  araddr     = 8'h00;
  logic [31:0] wdata      = 32'h0000_0000;
  logic [3:0]  wstrb      = 4'h0;
  logic        awvalid    = 1'b0;
  logic        wvalid     = 1'b0;
  logic        bready     = 1'b0;
  logic        arvalid    = 1'b0;
  logic        rready     = 1'b0;
  logic        idle       = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, adc;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  pins;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  int          errors       = 0;
  int          total_checks = 0;
  int          adc_n        = 0;
  int          n, p, c;

  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  pdt_timer_pairs u_pdt_timer_pairs (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .ext_clock_pin_in(pins),
    .idle_mode_in(idle), .irq_out(irq), .adc_trigger_out(adc)
  );

  pdt_pin_model u_pin (.clk_in(clk_in), .pins_out(pins));

  // Byte address of a register within timer t
  function automatic logic [7:0] ra(input int t, input logic [7:0] off);
    return 8'(t * 16) + off;
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Watcher: oldest expectation against each answer as it appears
  always @(posedge clk_in) begin
    if (rvalid && rready) chk({rresp, rdata}, rd_q.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, wr_q.pop_front()});
    if (adc === 1'b1) adc_n++;
  end

  task automatic give_verdict;
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // A wait that ran out counts as a mismatch and ends the run
  task automatic bail;
    errors++;
    give_verdict();
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] e = OK);
    int k;
    k = 0;
    wr_q.push_back(e);
    @(posedge clk_in);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    wstrb   <= 4'h3;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (k > 40) bail();
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  // Read: expectation noted first, watcher compares on the answer
  task automatic rd(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] e = OK);
    int k;
    k = 0;
    rd_q.push_back({e, 16'h0000, d});
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (k > 40) bail();
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask

  // Cycles until the interrupt line rises, bounded
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clk_in);
      n++;
      if (n > lim) bail();
    end
  endtask

  // Main sequence
  initial begin
    p = $urandom(32'h7b72);
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    // Reset values, implemented bits and an unmapped place
    rd(ra(0, CT), pdt_pkg::CTRL_RST);
    rd(ra(0, PE), pdt_pkg::PERIOD_RST);
    wr(ra(0, CT), 16'hFFFF);
    rd(ra(0, CT), pdt_pkg::CTRL_MASK_EVEN);
    wr(ra(1, CT), 16'hFFFF);
    rd(ra(1, CT), pdt_pkg::CTRL_MASK_ODD);
    wr(ra(0, CT), 16'h0000);
    wr(ra(1, CT), 16'h0000);
    wr(8'h50, 16'h1234, pdt_pkg::RESP_SLVERR);
    rd(8'h50, 16'h0000, pdt_pkg::RESP_SLVERR);
    wr(MK, 16'h000F);
    // Lone even timer, internal clock 1:1, random short period
    p = $urandom_range(9, 2);
    wr(ra(0, CN), 16'h0000);
    wr(ra(0, PE), 16'(p));
    wr(ra(0, CT), C_RUN);
    wait_irq(4 * p + 20);
    chk(34'(n >= 2 * p - 2 && n <= 2 * p + 5), 34'h1);
    wr(ra(0, CT), 16'h0000);
    rd(ST, 16'h0001);
    wr(MK, 16'h000E);
    chk(34'(irq), 34'h0);
    wr(ST, 16'h0001);
    rd(ST, 16'h0000);
    wr(MK, 16'h000F);
    // Pair A as one 32-bit timer; odd control holds junk to be ignored
    wr(ra(0, CT), C_PAIR);
    wr(ra(1, CT), 16'hA072);
    wr(ra(0, PE), 16'hFFFF);
    wr(ra(1, PE), 16'h0001);
    wr(ra(0, CN), 16'hFFFE);
    wr(ra(1, CN), 16'h0000);
    wr(ra(0, CT), C_PAIR | C_RUN);
    repeat (20) @(posedge clk_in);
    wr(ra(0, CT), C_PAIR);
    rd(ra(1, CN), 16'h0001);
    rd(ST, 16'h0000);
    // Now let it reach the full 32-bit period
    wr(ra(0, CN), 16'h0000);
    wr(ra(0, PE), 16'h0020);
    wr(ra(0, CT), C_PAIR | C_RUN);
    wait_irq(120);
    wr(ra(1, CT), 16'h0000);
    wr(ra(0, CT), 16'h0000);
    rd(ST, 16'h0002);
    chk(34'(adc_n), 34'h1);
    wr(ST, 16'h000F);
    // Pin clock through every prescale ratio, control write restarts it
    for (int k = 0; k < 4; k++) begin
      c = $urandom_range(1000, 0);
      wr(ra(2, CT), C_RUN | C_EXT | 16'(k << 4));
      wr(ra(2, CN), 16'(c));
      u_pin.pulse(2, 256);
      rd(ra(2, CN), 16'(c + (256 >> (k == 3 ? 8 : 3 * k))));
    end
    // Idle stop set halts the timer, clear keeps it counting
    idle <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(ra(2, CT), C_RUN | C_EXT | (s != 0 ? 16'h0000 : C_IDLE));
      wr(ra(2, CN), 16'h0000);
      u_pin.pulse(2, 8);
      rd(ra(2, CN), s != 0 ? 16'h0008 : 16'h0000);
    end
    idle <= 1'b0;
    wr(ra(2, CT), 16'h0000);
    // Gate with pin low holds the count; with pin clock it is ignored
    for (int s = 0; s < 2; s++) begin
      wr(ra(3, CT), C_RUN | C_GATE | (s != 0 ? C_EXT : 16'h0000));
      wr(ra(3, CN), 16'h0000);
      if (s != 0) u_pin.pulse(3, 8);
      else repeat (48) @(posedge clk_in);
      rd(ra(3, CN), s != 0 ? 16'h0008 : 16'h0000);
    end
    chk(34'(adc_n), 34'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
